/* common/dtcp_defs.vh */
`ifndef DTCP_DEFS_VH
`define DTCP_DEFS_VH

// register byte addresses
`define DTCP_ADDR_W          12
`define DTCP_OFS_CTRL        12'h410
`define DTCP_OFS_SYSCFG      12'h440
`define DTCP_OFS_MODE        12'h45c
`define DTCP_OFS_CNT0_LO     12'h460
`define DTCP_OFS_CNT0_HI     12'h464
`define DTCP_OFS_CNT1_LO     12'h468
`define DTCP_OFS_CNT1_HI     12'h46c
`define DTCP_OFS_RLD0_LO     12'h470
`define DTCP_OFS_RLD0_HI     12'h474
`define DTCP_OFS_RLD1_LO     12'h478
`define DTCP_OFS_RLD1_HI     12'h47c

// system config fields
`define DTCP_SYSCFG_PS_HI    3
`define DTCP_SYSCFG_PS_LO    2
`define DTCP_SYSCFG_RST      8'h00

// control register fields
`define DTCP_CTRL_OVF1       7
`define DTCP_CTRL_RUN1       6
`define DTCP_CTRL_OVF0       5
`define DTCP_CTRL_RUN0       4
`define DTCP_CTRL_RST        8'h00

// mode register fields, per timer nibble
`define DTCP_MODE_RST        8'h00
`define DTCP_MF_GATE         3
`define DTCP_MF_CSEL         2
`define DTCP_MF_HI           1
`define DTCP_MF_LO           0
`define DTCP_M_RLD16         2'b00
`define DTCP_M_FREE16        2'b01
`define DTCP_M_RLD8          2'b10
`define DTCP_M_SPLIT         2'b11

// prescaler select codes and last prescaler counts (oscillator divisor minus one)
`define DTCP_PS_DIV4         2'b00
`define DTCP_PS_DIV16        2'b01
`define DTCP_PS_DIV64        2'b10
`define DTCP_DIV4_LAST       6'h03
`define DTCP_DIV16_LAST      6'h0f
`define DTCP_DIV64_LAST      6'h3f

// count pins are sampled every this many oscillator cycles
`define DTCP_SAMPLE_CYCLES   2

`endif

/* src/dtcp_pin_sampler.v */
`timescale 1ns/1ps
`default_nettype none
module dtcp_pin_sampler (
    input  wire       clk_in,
    input  wire       arst_n_in,
    input  wire       phase_in,
    input  wire       pin_in,
    output reg        level_out,
    output reg        fall_out
);
    reg sync1_r;
    reg sync2_r;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_r   <= 1'b1;
            sync2_r   <= 1'b1;
            level_out <= 1'b1;
            fall_out  <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            if (phase_in) begin
                // sample once per two oscillator cycles, flag high-to-low
                level_out <= sync2_r;
                fall_out  <= level_out & ~sync2_r;
            end else begin
                fall_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* src/dtcp_top.v */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dtcp_defs.vh"
// Operation
// R1: select code picks oscillator divide 4/16/64
// R2: one timer clock shared by all timers
// R3: prescale select resets to divide by 4
// R4: counter mode counts count pin falling edges
// R5: count pins sampled every two oscillator cycles
// R6: source holds each level two oscillator cycles
// R7: counter-select picks timer clock or pin
// R8: gate bit adds interrupt pin to run
// R9: mode register: timer 1 upper nibble
// R10: mode bits choose four operating modes
// R11: mode 0 high overflow reloads both bytes
// R12: 8-bit reload uses low reload register
// R13: mode 0 rate follows 65536 minus reload
// R14: count up, counts readable any time
// R15: mode 2 reloads low byte only
// R16: timer 1 in mode 3 holds count
// R17: split mode high byte uses timer 1 controls
// R18: overflow flag cleared by vector or software
// R19: timer mode advances once per timer tick
module dtcp_top (
    input  wire        CORE_CLK_IN,
    input  wire        ARST_N_IN,
    input  wire [11:0] ADDR_IN,
    input  wire [7:0]  WDATA_IN,
    input  wire        WR_IN,
    input  wire        RD_IN,
    input  wire        COUNT_PIN0_IN,
    input  wire        COUNT_PIN1_IN,
    input  wire        EXT_INT_PIN0_IN,
    input  wire        EXT_INT_PIN1_IN,
    input  wire        VECTOR_ACK0_IN,
    input  wire        VECTOR_ACK1_IN,
    output reg  [7:0]  RDATA_OUT,
    output reg         OVERFLOW_FLAG0_OUT,
    output reg         OVERFLOW_FLAG1_OUT,
    output reg         TIMER_BASE_TICK_OUT
);
    reg  [1:0] prescale_sel_r;
    reg  [7:0] timer_mode_r;
    reg        run_bit0_r;
    reg        run_bit1_r;
    reg  [5:0] pre_cnt_r;
    reg  [5:0] pre_last;
    reg        phase_r;
    reg  [7:0] cnt_lo_r [0:1];
    reg  [7:0] cnt_hi_r [0:1];
    reg  [7:0] rld_lo_r [0:1];
    reg  [7:0] rld_hi_r [0:1];
    reg  [7:0] cnt_lo_nxt [0:1];
    reg  [7:0] cnt_hi_nxt [0:1];
    reg  [1:0] ovf;
    reg        ovf_split_hi;
    reg  [1:0] inc;
    reg  [1:0] md;
    reg  [3:0] nib;
    reg  [7:0] rd_nxt;
    reg        flag0_nxt;
    reg        flag1_nxt;
    integer    i;
    integer    j;

    wire       lvl_cnt0;
    wire       lvl_cnt1;
    wire       fall_cnt0;
    wire       fall_cnt1;
    wire       lvl_int0;
    wire       lvl_int1;
    wire [1:0] fall_cnt;
    wire [1:0] lvl_int;
    wire       split0;
    wire       wr_ctrl;

    dtcp_pin_sampler u_cnt0 (
        .clk_in    (CORE_CLK_IN),
        .arst_n_in (ARST_N_IN),
        .phase_in  (phase_r),
        .pin_in    (COUNT_PIN0_IN),
        .level_out (lvl_cnt0),
        .fall_out  (fall_cnt0)
    );
    dtcp_pin_sampler u_cnt1 (
        .clk_in    (CORE_CLK_IN),
        .arst_n_in (ARST_N_IN),
        .phase_in  (phase_r),
        .pin_in    (COUNT_PIN1_IN),
        .level_out (lvl_cnt1),
        .fall_out  (fall_cnt1)
    );
    dtcp_pin_sampler u_int0 (
        .clk_in    (CORE_CLK_IN),
        .arst_n_in (ARST_N_IN),
        .phase_in  (phase_r),
        .pin_in    (EXT_INT_PIN0_IN),
        .level_out (lvl_int0),
        .fall_out  ()
    );
    dtcp_pin_sampler u_int1 (
        .clk_in    (CORE_CLK_IN),
        .arst_n_in (ARST_N_IN),
        .phase_in  (phase_r),
        .pin_in    (EXT_INT_PIN1_IN),
        .level_out (lvl_int1),
        .fall_out  ()
    );

    assign fall_cnt = {fall_cnt1, fall_cnt0};
    assign lvl_int  = {lvl_int1, lvl_int0};
    assign split0   = (timer_mode_r[1:0] == `DTCP_M_SPLIT);
    assign wr_ctrl  = WR_IN && (ADDR_IN == `DTCP_OFS_CTRL);

    // prescaler terminal count
    always @* begin
        case (prescale_sel_r)
            `DTCP_PS_DIV4:  pre_last = `DTCP_DIV4_LAST; // see R1
            `DTCP_PS_DIV16: pre_last = `DTCP_DIV16_LAST; // see R1
            default:        pre_last = `DTCP_DIV64_LAST; // see R1
        endcase
    end

    // count step per timer and next counts
    always @* begin
        ovf_split_hi = 1'b0;
        for (i = 0; i < 2; i = i + 1) begin
            nib = (i == 0) ? timer_mode_r[3:0] : timer_mode_r[7:4]; // see R9
            md  = nib[`DTCP_MF_HI:`DTCP_MF_LO]; // see R10
            inc[i] = ((i == 0) ? run_bit0_r : run_bit1_r)
                     & (~nib[`DTCP_MF_GATE] | lvl_int[i]) // see R8
                     & (nib[`DTCP_MF_CSEL] ? fall_cnt[i] : TIMER_BASE_TICK_OUT); // see R7, R4, R19
            cnt_lo_nxt[i] = cnt_lo_r[i];
            cnt_hi_nxt[i] = cnt_hi_r[i];
            ovf[i] = 1'b0;
            case (md)
                `DTCP_M_RLD16: begin
                    if (inc[i]) begin
                        if ({cnt_hi_r[i], cnt_lo_r[i]} == 16'hffff) begin
                            cnt_lo_nxt[i] = rld_lo_r[i]; // see R11, R13
                            cnt_hi_nxt[i] = rld_hi_r[i]; // see R11
                            ovf[i] = 1'b1;
                        end else begin
                            {cnt_hi_nxt[i], cnt_lo_nxt[i]} = {cnt_hi_r[i], cnt_lo_r[i]} + 16'h0001; // see R14
                        end
                    end
                end
                `DTCP_M_FREE16: begin
                    if (inc[i]) begin
                        {cnt_hi_nxt[i], cnt_lo_nxt[i]} = {cnt_hi_r[i], cnt_lo_r[i]} + 16'h0001;
                        ovf[i] = ({cnt_hi_r[i], cnt_lo_r[i]} == 16'hffff);
                    end
                end
                `DTCP_M_RLD8: begin
                    if (inc[i]) begin
                        if (cnt_lo_r[i] == 8'hff) begin
                            cnt_lo_nxt[i] = rld_lo_r[i]; // see R12, R15
                            ovf[i] = 1'b1;
                        end else begin
                            cnt_lo_nxt[i] = cnt_lo_r[i] + 8'h01;
                        end
                    end
                end
                default: begin
                    if (i == 0) begin
                        // low byte keeps timer 0 controls; high byte is a timer on the other run bit
                        if (inc[i]) begin
                            cnt_lo_nxt[i] = cnt_lo_r[i] + 8'h01; // see R17
                            ovf[i] = (cnt_lo_r[i] == 8'hff);
                        end
                        if (run_bit1_r && TIMER_BASE_TICK_OUT) begin
                            cnt_hi_nxt[i] = cnt_hi_r[i] + 8'h01; // see R17
                            ovf_split_hi = (cnt_hi_r[i] == 8'hff);
                        end
                    end
                    // timer 1 here simply holds its count, see R16
                end
            endcase
        end
    end

    // overflow flags: hardware set wins over either clear
    always @* begin
        flag0_nxt = OVERFLOW_FLAG0_OUT;
        flag1_nxt = OVERFLOW_FLAG1_OUT;
        if (wr_ctrl) begin
            flag0_nxt = WDATA_IN[`DTCP_CTRL_OVF0]; // see R18
            flag1_nxt = WDATA_IN[`DTCP_CTRL_OVF1]; // see R18
        end
        if (VECTOR_ACK0_IN) begin
            flag0_nxt = 1'b0; // see R18
        end
        if (VECTOR_ACK1_IN) begin
            flag1_nxt = 1'b0; // see R18
        end
        if (ovf[0]) begin
            flag0_nxt = 1'b1;
        end
        if (split0 ? ovf_split_hi : ovf[1]) begin
            flag1_nxt = 1'b1; // see R17
        end
    end

    // read mux
    always @* begin
        case (ADDR_IN)
            `DTCP_OFS_CTRL:    rd_nxt = {OVERFLOW_FLAG1_OUT, run_bit1_r, OVERFLOW_FLAG0_OUT, run_bit0_r, 4'h0};
            `DTCP_OFS_SYSCFG:  rd_nxt = {4'h0, prescale_sel_r, 2'h0};
            `DTCP_OFS_MODE:    rd_nxt = timer_mode_r;
            `DTCP_OFS_CNT0_LO: rd_nxt = cnt_lo_r[0]; // see R14
            `DTCP_OFS_CNT0_HI: rd_nxt = cnt_hi_r[0];
            `DTCP_OFS_CNT1_LO: rd_nxt = cnt_lo_r[1];
            `DTCP_OFS_CNT1_HI: rd_nxt = cnt_hi_r[1];
            `DTCP_OFS_RLD0_LO: rd_nxt = rld_lo_r[0];
            `DTCP_OFS_RLD0_HI: rd_nxt = rld_hi_r[0];
            `DTCP_OFS_RLD1_LO: rd_nxt = rld_lo_r[1];
            `DTCP_OFS_RLD1_HI: rd_nxt = rld_hi_r[1];
            default:           rd_nxt = 8'h00;
        endcase
    end

    always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            prescale_sel_r      <= `DTCP_PS_DIV4; // see R3
            timer_mode_r        <= `DTCP_MODE_RST;
            run_bit0_r          <= 1'b0;
            run_bit1_r          <= 1'b0;
            pre_cnt_r           <= 6'h00;
            phase_r             <= 1'b0;
            TIMER_BASE_TICK_OUT <= 1'b0;
            OVERFLOW_FLAG0_OUT  <= 1'b0;
            OVERFLOW_FLAG1_OUT  <= 1'b0;
            RDATA_OUT           <= 8'h00;
            for (j = 0; j < 2; j = j + 1) begin
                cnt_lo_r[j] <= 8'h00;
                cnt_hi_r[j] <= 8'h00;
                rld_lo_r[j] <= 8'h00;
                rld_hi_r[j] <= 8'h00;
            end
        end else begin
            // count pins sampled on alternate oscillator cycles
            phase_r <= ~phase_r; // see R5
            // single shared timer clock for every timer
            if (pre_cnt_r >= pre_last) begin
                pre_cnt_r           <= 6'h00;
                TIMER_BASE_TICK_OUT <= 1'b1; // see R2
            end else begin
                pre_cnt_r           <= pre_cnt_r + 6'h01;
                TIMER_BASE_TICK_OUT <= 1'b0;
            end
            OVERFLOW_FLAG0_OUT <= flag0_nxt;
            OVERFLOW_FLAG1_OUT <= flag1_nxt;
            RDATA_OUT          <= RD_IN ? rd_nxt : 8'h00;
            for (j = 0; j < 2; j = j + 1) begin
                cnt_lo_r[j] <= cnt_lo_nxt[j];
                cnt_hi_r[j] <= cnt_hi_nxt[j];
            end
            // a software write overrides a count step in the same cycle
            if (WR_IN) begin
                case (ADDR_IN)
                    `DTCP_OFS_CTRL: begin
                        run_bit0_r <= WDATA_IN[`DTCP_CTRL_RUN0];
                        run_bit1_r <= WDATA_IN[`DTCP_CTRL_RUN1];
                    end
                    `DTCP_OFS_SYSCFG:  prescale_sel_r <= WDATA_IN[`DTCP_SYSCFG_PS_HI:`DTCP_SYSCFG_PS_LO];
                    `DTCP_OFS_MODE:    timer_mode_r <= WDATA_IN;
                    `DTCP_OFS_CNT0_LO: cnt_lo_r[0] <= WDATA_IN;
                    `DTCP_OFS_CNT0_HI: cnt_hi_r[0] <= WDATA_IN;
                    `DTCP_OFS_CNT1_LO: cnt_lo_r[1] <= WDATA_IN;
                    `DTCP_OFS_CNT1_HI: cnt_hi_r[1] <= WDATA_IN;
                    `DTCP_OFS_RLD0_LO: rld_lo_r[0] <= WDATA_IN;
                    `DTCP_OFS_RLD0_HI: rld_hi_r[0] <= WDATA_IN;
                    `DTCP_OFS_RLD1_LO: rld_lo_r[1] <= WDATA_IN;
                    `DTCP_OFS_RLD1_HI: rld_hi_r[1] <= WDATA_IN;
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* verif/dtcp_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dtcp_pin_model (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic en_in,
    input  wire logic gate0_in,
    input  wire logic gate1_in,
    output logic      pin0_out,
    output logic      pin1_out,
    output logic      gate0_out,
    output logic      gate1_out
);
    logic [2:0] ph_r;
    // a started period always runs to its end, pins idle high
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            ph_r <= 3'h0;
        else if (en_in || ph_r != 3'h0)
            ph_r <= ph_r + 3'h1;
    end
    assign pin0_out  = ~ph_r[2];
    assign pin1_out  = ~ph_r[2];
    assign gate0_out = gate0_in;
    assign gate1_out = gate1_in;
endmodule
`default_nettype wire

/* verif/dtcp_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dtcp_defs.vh"
module dtcp_top_asserts (
    input wire logic        CORE_CLK_IN,
    input wire logic        ARST_N_IN,
    input wire logic [11:0] ADDR_IN,
    input wire logic [7:0]  WDATA_IN,
    input wire logic        WR_IN,
    input wire logic        RD_IN,
    input wire logic        VECTOR_ACK0_IN,
    input wire logic        VECTOR_ACK1_IN,
    input wire logic [7:0]  RDATA_OUT,
    input wire logic        OVERFLOW_FLAG0_OUT,
    input wire logic        OVERFLOW_FLAG1_OUT,
    input wire logic        TIMER_BASE_TICK_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    sequence s_wr(a);
        WR_IN && ADDR_IN == a;
    endsequence
    sequence s_rd(a);
        RD_IN && ADDR_IN == a;
    endsequence
    property p_tick_gap;
        TIMER_BASE_TICK_OUT |=> !TIMER_BASE_TICK_OUT [*3];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick gap below four");
    property p_rd_idle;
        !RD_IN |=> RDATA_OUT == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_mode_rb;
        s_wr(`DTCP_OFS_MODE) ##2 s_rd(`DTCP_OFS_MODE) |=> RDATA_OUT == $past(WDATA_IN, 3);
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
    property p_cfg_rb;
        s_wr(`DTCP_OFS_SYSCFG) ##2 s_rd(`DTCP_OFS_SYSCFG) |=> RDATA_OUT == ($past(WDATA_IN, 3) & 8'h0c);
    endproperty
    a_cfg_rb: assert property (p_cfg_rb) else $error("config readback wrong");
    property p_set0;
        s_wr(`DTCP_OFS_CTRL) ##0 WDATA_IN[5] |=> OVERFLOW_FLAG0_OUT;
    endproperty
    a_set0: assert property (p_set0) else $error("flag0 write one lost");
    property p_set1;
        s_wr(`DTCP_OFS_CTRL) ##0 WDATA_IN[7] |=> OVERFLOW_FLAG1_OUT;
    endproperty
    a_set1: assert property (p_set1) else $error("flag1 write one lost");
    property p_fell0;
        $fell(OVERFLOW_FLAG0_OUT) |-> $past(VECTOR_ACK0_IN || (WR_IN && ADDR_IN == `DTCP_OFS_CTRL));
    endproperty
    a_fell0: assert property (p_fell0) else $error("flag0 dropped uncaused");
    property p_fell1;
        $fell(OVERFLOW_FLAG1_OUT) |-> $past(VECTOR_ACK1_IN || (WR_IN && ADDR_IN == `DTCP_OFS_CTRL));
    endproperty
    a_fell1: assert property (p_fell1) else $error("flag1 dropped uncaused");
    property p_ctrl_rd;
        s_rd(`DTCP_OFS_CTRL) |=> RDATA_OUT[7] == $past(OVERFLOW_FLAG1_OUT)
            && RDATA_OUT[5] == $past(OVERFLOW_FLAG0_OUT) && RDATA_OUT[3:0] == 4'h0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read flags wrong");
endmodule
bind dtcp_top dtcp_top_asserts chk (.CORE_CLK_IN, .ARST_N_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN,
    .VECTOR_ACK0_IN, .VECTOR_ACK1_IN, .RDATA_OUT, .OVERFLOW_FLAG0_OUT, .OVERFLOW_FLAG1_OUT,
    .TIMER_BASE_TICK_OUT);
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dtcp_defs.vh"
module tb_top;
    logic        clk, rst_n, wr, rd, ack0, ack1, pen, g0, g1;
    logic [11:0] addr;
    logic [7:0]  wdata;
    wire         p0, p1, gp0, gp1, f0, f1, tick;
    wire  [7:0]  rdata;
    int          n_fail = 0;
    int          tests_run = 0;
    int          c;
    dtcp_top uut (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .COUNT_PIN0_IN(p0), .COUNT_PIN1_IN(p1), .EXT_INT_PIN0_IN(gp0),
        .EXT_INT_PIN1_IN(gp1), .VECTOR_ACK0_IN(ack0), .VECTOR_ACK1_IN(ack1), .RDATA_OUT(rdata),
        .OVERFLOW_FLAG0_OUT(f0), .OVERFLOW_FLAG1_OUT(f1), .TIMER_BASE_TICK_OUT(tick));
    dtcp_pin_model pm (.clk_in(clk), .arst_n_in(rst_n), .en_in(pen), .gate0_in(g0), .gate1_in(g1),
        .pin0_out(p0), .pin1_out(p1), .gate0_out(gp0), .gate1_out(gp1));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_r(logic [11:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(string nm, logic [11:0] a, logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(nm, rdata, exp);
    endtask
    task automatic pulse(bit w);
        @(posedge clk);
        if (w) ack1 <= 1'b1; else ack0 <= 1'b1;
        @(posedge clk);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
    endtask
    task automatic wait_flag(bit w);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while ((w ? f1 : f0) !== 1'b1 && c < 900);
        chk("flag wait", {7'h0, (w ? f1 : f0)}, 8'h01);
    endtask
    task automatic tgap(output int g);
        g = 0;
        while (tick !== 1'b1 && g < 300) begin
            @(negedge clk);
            g++;
        end
        g = 0;
        do begin
            @(negedge clk);
            g++;
        end while (tick !== 1'b1 && g < 300);
        chk("tick wait", {7'h0, tick}, 8'h01);
    endtask
    task automatic t_reset;
        int g;
        rd_chk("syscfg", `DTCP_OFS_SYSCFG, 8'h00);
        rd_chk("mode", `DTCP_OFS_MODE, 8'h00);
        rd_chk("ctrl", `DTCP_OFS_CTRL, 8'h00);
        rd_chk("unmapped", 12'h000, 8'h00);
        wr_r(`DTCP_OFS_CTRL, 8'ha0);
        rd_chk("ctrl set", `DTCP_OFS_CTRL, 8'ha0);
        wr_r(`DTCP_OFS_CTRL, 8'h00);
        rd_chk("ctrl clr", `DTCP_OFS_CTRL, 8'h00);
        tgap(g);
        chk("gap4", g[7:0], 8'h04);
        $display("t_reset done");
    endtask
    task automatic t_prescale;
        int g;
        int dv [3] = '{16, 64, 64};
        for (int k = 1; k < 4; k++) begin
            wr_r(`DTCP_OFS_SYSCFG, 8'(k << 2));
            rd_chk("syscfg", `DTCP_OFS_SYSCFG, 8'(k << 2));
            tgap(g);
            tgap(g);
            chk("gap", g[7:0], 8'(dv[k-1]));
        end
        wr_r(`DTCP_OFS_SYSCFG, 8'h00);
        $display("t_prescale done");
    endtask
    task automatic t_mode0;
        wr_r(`DTCP_OFS_RLD0_LO, 8'hfe);
        wr_r(`DTCP_OFS_RLD0_HI, 8'hff);
        wr_r(`DTCP_OFS_CNT0_LO, 8'hfe);
        wr_r(`DTCP_OFS_CNT0_HI, 8'hff);
        wr_r(`DTCP_OFS_CTRL, 8'h10);
        wait_flag(0);
        rd_chk("reload lo", `DTCP_OFS_CNT0_LO, 8'hfe);
        pulse(0);
        wait_flag(0);
        // period 4 * (65536 - 0xfffe); the wait starts 4 clocks after the overflow, counted at the next negedge
        chk("ovf period", 8'(c), 8'(4 * (65536 - 65534) - 3));
        wr_r(`DTCP_OFS_CTRL, 8'h00);
        $display("t_mode0 done");
    endtask
    task automatic t_mode2;
        wr_r(`DTCP_OFS_MODE, 8'h20);
        wr_r(`DTCP_OFS_CNT1_HI, 8'h55);
        wr_r(`DTCP_OFS_CNT1_LO, 8'hfe);
        wr_r(`DTCP_OFS_RLD1_LO, 8'h80);
        wr_r(`DTCP_OFS_RLD1_HI, 8'h11);
        wr_r(`DTCP_OFS_CTRL, 8'h40);
        wait_flag(1);
        wr_r(`DTCP_OFS_CTRL, 8'h00);
        @(negedge clk);
        chk("flag1 cleared", {7'h0, f1}, 8'h00);
        rd_chk("lo", `DTCP_OFS_CNT1_LO, 8'h80);
        rd_chk("hi", `DTCP_OFS_CNT1_HI, 8'h55);
        $display("t_mode2 done");
    endtask
    task automatic t_counter;
        wr_r(`DTCP_OFS_CNT0_LO, 8'h00);
        wr_r(`DTCP_OFS_MODE, 8'h05);
        rd_chk("mode", `DTCP_OFS_MODE, 8'h05);
        wr_r(`DTCP_OFS_CTRL, 8'h10);
        for (int k = 0; k < 3; k++) begin
            g0 <= (k == 2);
            if (k == 1) wr_r(`DTCP_OFS_MODE, 8'h0d);
            repeat (8) @(posedge clk);
            pen <= 1'b1;
            repeat (8 * (k + 2)) @(posedge clk);
            pen <= 1'b0;
            repeat (12) @(posedge clk);
            rd_chk("events", `DTCP_OFS_CNT0_LO, k == 0 ? 8'h02 : (k == 1 ? 8'h02 : 8'h06));
        end
        wr_r(`DTCP_OFS_CTRL, 8'h00);
        $display("t_counter done");
    endtask
    task automatic t_mode3;
        wr_r(`DTCP_OFS_MODE, 8'h33);
        wr_r(`DTCP_OFS_CNT1_LO, 8'h10);
        wr_r(`DTCP_OFS_CNT0_LO, 8'hff);
        wr_r(`DTCP_OFS_CNT0_HI, 8'hff);
        wr_r(`DTCP_OFS_CTRL, 8'h50);
        wait_flag(0);
        wait_flag(1);
        chk("split flags", {6'h0, f1, f0}, 8'h03);
        pulse(1);
        @(negedge clk);
        chk("ack1", {7'h0, f1}, 8'h00);
        wr_r(`DTCP_OFS_CTRL, 8'h00);
        rd_chk("t1 held", `DTCP_OFS_CNT1_LO, 8'h10);
        $display("t_mode3 done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        print_verdict();
    end
    initial begin
        {rst_n, wr, rd, ack0, ack1, pen} = 6'h0;
        {g0, g1} = 2'b11;
        addr = 12'h000;
        wdata = 8'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_prescale();
        t_mode0();
        t_mode2();
        t_counter();
        t_mode3();
        print_verdict();
    end
endmodule
`default_nettype wire
